/* File: fss_params.svh */
// constants of the flash security and signature block
//
// Summary of operation
// - signature answer opens with a three-byte device identification code.
// - then ten bytes of device name in ASCII.
// - then code flash last address, three bytes, low byte first.
// - then data flash last address, three bytes, low byte first.
// - then firmware version, three bytes, major digit first, one digit each.
// - erase-prohibit refuses serial block erase; serial writes still run.
// - write-prohibit refuses serial writes to every block; erase still runs.
// - self-programming erase and write ignore both prohibit settings.
// - blank nonvolatile store means both prohibits off, commands accepted.
// - both prohibits independent, settable by serial command or self-programming.
// - erase-prohibit, once set, can never be cleared.
// - security-release command clears the write-prohibit setting.
// - a release takes effect only after the next reset.
// - release accepted only with erase-prohibit off and both areas blank.
// - refused command gets a negative acknowledge, accepted one a positive.
`ifndef FSS_PARAMS_SVH
`define FSS_PARAMS_SVH
`define FSS_ACK 8'h06
`define FSS_NAK 8'h15
`define FSS_ID_END 5'h03
`define FSS_NAME_END 5'h0d
`define FSS_CODE_END 5'h10
`define FSS_DATA_END 5'h13
`define FSS_SIG_LAST 5'h15
`define FSS_FIFO_DEPTH 16
`define FSS_BYTE_W 8
`endif

/* File: fss_pkg.sv */
// types of the flash security and signature block
package fss_pkg;
  typedef enum logic [2:0] {
    FSS_CMD_SIG = 3'h0,
    FSS_CMD_ERASE = 3'h1,
    FSS_CMD_WRITE = 3'h2,
    FSS_CMD_SEC_SET = 3'h3,
    FSS_CMD_SEC_REL = 3'h4
  } fss_cmd_t;
  typedef enum logic [2:0] {
    FSS_ST_LOAD = 3'h1,
    FSS_ST_IDLE = 3'h2,
    FSS_ST_SIG = 3'h4
  } fss_state_t;
endpackage

/* File: fss_sec.sv */
// flash security policy, signature answer and response fifo
`timescale 1ns/1ps
`include "fss_params.svh"

module fss_fifo #(
  parameter int W = `FSS_BYTE_W,
  parameter int D = `FSS_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic ne;
    logic [W-1:0] head;
  } fss_fifo_st_t;
  fss_fifo_st_t s_ff;
  fss_fifo_st_t nxt_s;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign o_in_ready = s_ff.cnt != (AW+1)'(D);
  assign o_out_valid = s_ff.ne;
  assign o_out_data = s_ff.head;
  assign push = i_in_valid && o_in_ready;
  assign pop = s_ff.ne && i_out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.wp = (s_ff.wp == AW'(D-1)) ? '0 : s_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_s.rp = (s_ff.rp == AW'(D-1)) ? '0 : s_ff.rp + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    // flag and head byte are registered so the outputs come straight from flops
    nxt_s.ne = nxt_s.cnt != '0;
    nxt_s.head = (push && s_ff.wp == nxt_s.rp) ? i_in_data : mem[nxt_s.rp];
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[s_ff.wp] <= i_in_data;
    end
  end
endmodule // fss_fifo

module fss_sec #(
  parameter logic [23:0] DEV_CODE = 24'h5a_a5_3c, // arbitrary value
  parameter logic [79:0] DEV_NAME = 80'h46_4c_41_53_48_44_45_56_30_31,
  parameter logic [23:0] CODE_LAST = 24'h00_3f_ff,
  parameter logic [23:0] DATA_LAST = 24'h0f_17_ff,
  parameter logic [23:0] FW_VER = 24'h01_02_03
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_serial_mode,
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_code,
  input wire logic i_cmd_set_erase,
  input wire logic i_cmd_set_write,
  output logic o_cmd_ready,
  input wire logic i_self_erase,
  input wire logic i_self_write,
  input wire logic i_self_set_erase,
  input wire logic i_self_set_write,
  input wire logic i_code_blank,
  input wire logic i_data_blank,
  input wire logic i_nv_erase_prot,
  input wire logic i_nv_write_prot,
  output logic o_nv_wr,
  output logic o_nv_erase_prot,
  output logic o_nv_write_prot,
  output logic o_erase_go,
  output logic o_write_go,
  output logic o_erase_prot,
  output logic o_write_prot,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  input wire logic i_rsp_ready
);
  typedef struct packed {
    fss_pkg::fss_state_t st;
    logic [4:0] idx;
    logic erase_prot;
    logic write_prot;
    logic nv_e;
    logic nv_w;
    logic nv_wr;
    logic push_v;
    logic [7:0] push_d;
    logic erase_go;
    logic write_go;
    logic cmd_ready;
  } fss_sec_st_t;
  fss_sec_st_t s_ff;
  fss_sec_st_t nxt_s;
  logic fifo_in_ready;
  logic slot_free;
  logic cmd_take;
  logic [7:0] sig_now;

  // ---------------------------------------------------------------
  // signature byte lookup
  // ---------------------------------------------------------------
  function automatic logic [7:0] sig_byte(input logic [4:0] idx);
    int k;
    k = int'(idx);
    if (idx < `FSS_ID_END) begin
      sig_byte = DEV_CODE[23-8*k -: 8];
    end else if (idx < `FSS_NAME_END) begin
      sig_byte = DEV_NAME[79-8*(k-3) -: 8];
    end else if (idx < `FSS_CODE_END) begin
      sig_byte = CODE_LAST[8*(k-13) +: 8];
    end else if (idx < `FSS_DATA_END) begin
      sig_byte = DATA_LAST[8*(k-16) +: 8];
    end else begin
      sig_byte = FW_VER[23-8*(k-19) -: 8];
    end
  endfunction

  assign sig_now = sig_byte(s_ff.idx);
  assign slot_free = !s_ff.push_v || fifo_in_ready;
  assign cmd_take = i_cmd_valid && s_ff.cmd_ready;

  // ---------------------------------------------------------------
  // command policy
  // ---------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.erase_go = 1'b0;
    nxt_s.write_go = 1'b0;
    nxt_s.nv_wr = 1'b0;
    if (slot_free) begin
      nxt_s.push_v = 1'b0;
    end
    unique case (s_ff.st)
      fss_pkg::FSS_ST_LOAD: begin
        // settings come back from the store after every reset
        nxt_s.erase_prot = i_nv_erase_prot;
        nxt_s.write_prot = i_nv_write_prot;
        nxt_s.nv_e = i_nv_erase_prot;
        nxt_s.nv_w = i_nv_write_prot;
        nxt_s.st = fss_pkg::FSS_ST_IDLE;
      end
      fss_pkg::FSS_ST_IDLE: begin
        if (cmd_take) begin
          nxt_s.push_v = 1'b1;
          nxt_s.push_d = `FSS_ACK;
          unique case (i_cmd_code)
            fss_pkg::FSS_CMD_SIG: begin
              nxt_s.st = fss_pkg::FSS_ST_SIG;
              nxt_s.idx = '0;
            end
            fss_pkg::FSS_CMD_ERASE: begin
              if (s_ff.erase_prot) begin
                nxt_s.push_d = `FSS_NAK;
              end else begin
                nxt_s.erase_go = 1'b1;
              end
            end
            fss_pkg::FSS_CMD_WRITE: begin
              if (s_ff.write_prot) begin
                nxt_s.push_d = `FSS_NAK;
              end else begin
                nxt_s.write_go = 1'b1;
              end
            end
            fss_pkg::FSS_CMD_SEC_SET: begin
              nxt_s.erase_prot = s_ff.erase_prot | i_cmd_set_erase;
              nxt_s.write_prot = s_ff.write_prot | i_cmd_set_write;
              nxt_s.nv_e = s_ff.nv_e | i_cmd_set_erase;
              nxt_s.nv_w = s_ff.nv_w | i_cmd_set_write;
              nxt_s.nv_wr = 1'b1;
            end
            fss_pkg::FSS_CMD_SEC_REL: begin
              if (s_ff.erase_prot || !i_code_blank || !i_data_blank) begin
                nxt_s.push_d = `FSS_NAK;
              end else begin
                // only the stored copy is cleared; the live one waits for reset
                nxt_s.nv_w = 1'b0;
                nxt_s.nv_wr = 1'b1;
              end
            end
            default: begin
              nxt_s.push_d = `FSS_NAK;
            end
          endcase
        end else if (!i_serial_mode) begin
          // self-programming bypasses both prohibits
          nxt_s.erase_go = i_self_erase;
          nxt_s.write_go = i_self_write && !i_self_erase;
          if (i_self_set_erase || i_self_set_write) begin
            nxt_s.erase_prot = s_ff.erase_prot | i_self_set_erase;
            nxt_s.write_prot = s_ff.write_prot | i_self_set_write;
            nxt_s.nv_e = s_ff.nv_e | i_self_set_erase;
            nxt_s.nv_w = s_ff.nv_w | i_self_set_write;
            nxt_s.nv_wr = 1'b1;
          end
        end
      end
      fss_pkg::FSS_ST_SIG: begin
        if (slot_free) begin
          nxt_s.push_v = 1'b1;
          nxt_s.push_d = sig_now;
          nxt_s.idx = s_ff.idx + 5'h01;
          if (s_ff.idx == `FSS_SIG_LAST) begin
            nxt_s.st = fss_pkg::FSS_ST_IDLE;
          end
        end
      end
      default: begin
        nxt_s.st = fss_pkg::FSS_ST_IDLE;
      end
    endcase
    nxt_s.cmd_ready = i_serial_mode && (nxt_s.st == fss_pkg::FSS_ST_IDLE) && !nxt_s.push_v;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '{st: fss_pkg::FSS_ST_LOAD, push_d: 8'h00, idx: 5'h00, default: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  fss_fifo #(.W(`FSS_BYTE_W), .D(`FSS_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(s_ff.push_v),
    .i_in_data(s_ff.push_d),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_rsp_valid),
    .o_out_data(o_rsp_data),
    .i_out_ready(i_rsp_ready)
  );

  assign o_cmd_ready = s_ff.cmd_ready;
  assign o_nv_wr = s_ff.nv_wr;
  assign o_nv_erase_prot = s_ff.nv_e;
  assign o_nv_write_prot = s_ff.nv_w;
  assign o_erase_go = s_ff.erase_go;
  assign o_write_go = s_ff.write_go;
  assign o_erase_prot = s_ff.erase_prot;
  assign o_write_prot = s_ff.write_prot;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_sig_bytes: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ff.st == fss_pkg::FSS_ST_SIG && slot_free) |=> s_ff.push_v && s_ff.push_d == $past(sig_now))
    else $error("signature byte wrong");
  chk_erase_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_ERASE && s_ff.erase_prot)
      |=> s_ff.push_d == `FSS_NAK && !s_ff.erase_go)
    else $error("erase not refused");
  chk_write_refused: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_WRITE && s_ff.write_prot)
      |=> s_ff.push_d == `FSS_NAK && !s_ff.write_go)
    else $error("write not refused");
  chk_erase_allowed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_ERASE && !s_ff.erase_prot)
      |=> s_ff.erase_go && s_ff.push_d == `FSS_ACK ##1 !s_ff.erase_go)
    else $error("erase not granted");
  chk_self_exempt: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ff.st == fss_pkg::FSS_ST_IDLE && !i_serial_mode && !cmd_take && i_self_erase) |=> s_ff.erase_go)
    else $error("self erase blocked");
  chk_erase_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (s_ff.erase_prot && s_ff.nv_e) |=> s_ff.erase_prot && s_ff.nv_e)
    else $error("erase prohibit cleared");
  chk_release_late: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_SEC_REL) |=> s_ff.write_prot == $past(s_ff.write_prot))
    else $error("release took effect early");
  chk_release_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_SEC_REL && (s_ff.erase_prot || !i_code_blank || !i_data_blank))
      |=> s_ff.push_d == `FSS_NAK && !s_ff.nv_wr && s_ff.nv_w == $past(s_ff.nv_w))
    else $error("release not gated");
  chk_write_allowed: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_WRITE && !s_ff.write_prot)
      |=> s_ff.write_go && s_ff.push_d == `FSS_ACK ##1 !s_ff.write_go)
    else $error("write not granted");
  chk_release_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code == fss_pkg::FSS_CMD_SEC_REL && !s_ff.erase_prot && i_code_blank && i_data_blank)
      |=> s_ff.nv_wr && !s_ff.nv_w && s_ff.push_d == `FSS_ACK)
    else $error("release not stored");
  chk_illegal_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (cmd_take && i_cmd_code > 3'h4)
      |=> s_ff.push_d == `FSS_NAK && !s_ff.erase_go && !s_ff.write_go && !s_ff.nv_wr)
    else $error("illegal code not refused");
endmodule // fss_sec

/* File: fss_host.sv */
// programmer-side model that drains the response byte stream
`timescale 1ns/1ps
module fss_host (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  input wire logic [1:0] i_mode,
  output logic o_ready
);
  logic [7:0] got [$];
  logic ph_ff;
  // mode 0 takes every byte, 1 every other cycle, 2 stops taking
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_ff <= 1'b0;
    end else begin
      ph_ff <= ~ph_ff;
      if (i_valid && o_ready) begin
        got.push_back(i_data);
      end
    end
  end
  assign o_ready = i_rst_n && (i_mode == 2'h0 || (i_mode == 2'h1 && ph_ff));
endmodule // fss_host

/* File: fss_tb.sv */
// self-checking bench for the flash security and signature block
`timescale 1ns/1ps
`include "fss_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  localparam logic [23:0] DCODE = 24'h3c_c3_5a; // arbitrary value
  localparam logic [79:0] DNAME = 80'h54_45_53_54_50_41_52_54_30_39;
  localparam logic [23:0] CLAST = 24'h00_1f_ff;
  localparam logic [23:0] DLAST = 24'h0f_13_ff;
  localparam logic [23:0] FWV = 24'h04_05_06;
  logic i_clk = 1'b0, i_rst_n = 1'b0, smode = 1'b1, cv = 1'b0, se = 1'b0, sw = 1'b0;
  logic s_er = 1'b0, s_wr = 1'b0, s_se = 1'b0, s_sw = 1'b0, cblank = 1'b1, dblank = 1'b1;
  logic nv_e = 1'b0, nv_w = 1'b0, nv_wr, nv_eo, nv_wo, er_go, wr_go, er_p, wr_p, rv, rdy, crdy;
  logic [2:0] cc = 3'h0;
  logic [7:0] rd;
  logic [1:0] hmode = 2'h0;
  int fails = 0, checked = 0, n_er = 0, n_wr = 0;
  always #2 i_clk = ~i_clk;
  fss_sec #(.DEV_CODE(DCODE), .DEV_NAME(DNAME), .CODE_LAST(CLAST), .DATA_LAST(DLAST), .FW_VER(FWV)) uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_mode(smode), .i_cmd_valid(cv), .i_cmd_code(cc),
    .i_cmd_set_erase(se), .i_cmd_set_write(sw), .o_cmd_ready(crdy), .i_self_erase(s_er),
    .i_self_write(s_wr), .i_self_set_erase(s_se), .i_self_set_write(s_sw), .i_code_blank(cblank),
    .i_data_blank(dblank), .i_nv_erase_prot(nv_e), .i_nv_write_prot(nv_w), .o_nv_wr(nv_wr),
    .o_nv_erase_prot(nv_eo), .o_nv_write_prot(nv_wo), .o_erase_go(er_go), .o_write_go(wr_go),
    .o_erase_prot(er_p), .o_write_prot(wr_p), .o_rsp_valid(rv), .o_rsp_data(rd), .i_rsp_ready(rdy));
  fss_host host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(rv), .i_data(rd), .i_mode(hmode), .o_ready(rdy));
  // nonvolatile store and go pulse counters
  always @(posedge i_clk) begin
    if (nv_wr === 1'b1) begin
      nv_e <= nv_eo;
      nv_w <= nv_wo;
    end
    n_er <= n_er + int'(er_go === 1'b1);
    n_wr <= n_wr + int'(wr_go === 1'b1);
  end
  function automatic logic [7:0] sig_b(input int i);
    if (i < 3) return DCODE[23 - 8 * i -: 8];
    if (i < 13) return DNAME[79 - 8 * (i - 3) -: 8];
    if (i < 16) return CLAST[8 * (i - 13) +: 8];
    if (i < 19) return DLAST[8 * (i - 16) +: 8];
    return FWV[23 - 8 * (i - 19) -: 8];
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic rst(input logic e, input logic w);
    i_rst_n = 1'b0;
    nv_e = e;
    nv_w = w;
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [7:0] ack, input int ge, input int gw, input int nb);
    int e0, w0, k;
    e0 = n_er;
    w0 = n_wr;
    k = 0;
    host.got.delete();
    cc = c;
    cv = 1'b1;
    while (crdy !== 1'b1 && k < 50) begin
      @(posedge i_clk);
      #1 k++;
    end
    `CHK("cmd ready", 1'b1, crdy)
    @(posedge i_clk);
    #1 cv = 1'b0;
    k = 0;
    while (host.got.size() < nb && k < 400) begin
      @(posedge i_clk);
      #1 k++;
    end
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("byte count", nb, host.got.size())
    `CHK("ack", ack, host.got[0])
    `CHK("erase go", ge, n_er - e0)
    `CHK("write go", gw, n_wr - w0)
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge i_clk);
    #1 s = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic s_sig();
    hmode = 2'h2;
    fork
      begin
        repeat (60) @(posedge i_clk);
        #1;
        `CHK("busy while full", 1'b0, crdy)
        hmode = 2'h1;
      end
    join_none
    cmd(3'h0, `FSS_ACK, 0, 0, 23);
    `CHK("drained", 1'b0, rv)
    for (int i = 0; i < 22; i++) `CHK("signature", sig_b(i), host.got[i + 1])
    hmode = 2'h0;
  endtask
  task automatic s_open();
    cmd(3'h1, `FSS_ACK, 1, 0, 1);
    cmd(3'h2, `FSS_ACK, 0, 1, 1);
    for (int c = 5; c < 8; c++) cmd(3'(c), `FSS_NAK, 0, 0, 1);
  endtask
  task automatic s_erase_lock();
    se = 1'b1;
    cmd(3'h3, `FSS_ACK, 0, 0, 1);
    se = 1'b0;
    `CHK("erase lock", 1'b1, er_p)
    cmd(3'h1, `FSS_NAK, 0, 0, 1);
    cmd(3'h2, `FSS_ACK, 0, 1, 1);
    cmd(3'h4, `FSS_NAK, 0, 0, 1);
    rst(nv_e, nv_w);
    cmd(3'h1, `FSS_NAK, 0, 0, 1);
  endtask
  task automatic s_write_lock();
    rst(1'b0, 1'b0);
    sw = 1'b1;
    cmd(3'h3, `FSS_ACK, 0, 0, 1);
    sw = 1'b0;
    `CHK("write lock", 1'b1, wr_p)
    `CHK("erase open", 1'b0, er_p)
    rst(nv_e, nv_w);
    cmd(3'h2, `FSS_NAK, 0, 0, 1);
    cmd(3'h1, `FSS_ACK, 1, 0, 1);
    cblank = 1'b0;
    cmd(3'h4, `FSS_NAK, 0, 0, 1);
    cblank = 1'b1;
    dblank = 1'b0;
    cmd(3'h4, `FSS_NAK, 0, 0, 1);
    dblank = 1'b1;
    cmd(3'h4, `FSS_ACK, 0, 0, 1);
    `CHK("stored write lock", 1'b0, nv_w)
    `CHK("live write lock", 1'b1, wr_p)
    cmd(3'h2, `FSS_NAK, 0, 0, 1);
    rst(nv_e, nv_w);
    cmd(3'h2, `FSS_ACK, 0, 1, 1);
  endtask
  task automatic s_self();
    int e0, w0;
    rst(1'b1, 1'b1);
    smode = 1'b0;
    e0 = n_er;
    w0 = n_wr;
    pulse(s_er);
    pulse(s_wr);
    `CHK("self erase", 1, n_er - e0)
    `CHK("self write", 1, n_wr - w0)
    rst(1'b0, 1'b0);
    pulse(s_sw);
    `CHK("self write lock", 1'b1, wr_p)
    `CHK("erase still open", 1'b0, er_p)
    pulse(s_se);
    `CHK("self erase lock", 1'b1, er_p)
    smode = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 cmd(3'h2, `FSS_NAK, 0, 0, 1);
  endtask
  initial begin
    rst(1'b0, 1'b0);
    s_sig();
    s_open();
    s_erase_lock();
    s_write_lock();
    s_self();
    end_of_test();
  end
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule // testbench
